// [core/mec_core.sv]
// Instruction execution core: fetch, decode, execute, table read, watchdog clear.
// Assumes a program memory that returns the word at prog_addr_out in the same cycle.
// Functional notes
// RL1: Moves between memory, accumulator and immediate take one cycle, flags unchanged.
// RL2: Bit clear and bit set force one indexed bit, others kept.
// RL3: Call pushes next address then jumps; two cycles.
// RL4: Skips take two cycles when skipping, one otherwise.
// RL5: Skip on zero byte, zero bit or set bit; byte test may load accumulator.
// RL6: Increment or decrement, skip on zero result; variants write accumulator.
// RL7: Returns reload program counter from stack in two cycles.
// RL8: Interrupt return also sets master interrupt enable.
// RL9: Table reads fill high register and memory byte; two cycles.
// RL10: Writing program counter low byte costs two cycles.
// RL11: Clear byte writes zero, set byte writes ones; one cycle.
// RL12: Plain watchdog clear resets watchdog, timeout and power-down flags.
// RL13: Pre-clear pair acts only when the two alternate consecutively.
// RL14: Nibble swap in place or into accumulator, flags unchanged.
// RL15: Power-down takes one cycle, touching only timeout and power-down flags.
// RL16: Power-down stops execution, clears watchdog, sets power-down, clears timeout.
// RL17: Add and add-with-carry update overflow, zero, aux carry and carry.
// RL18: Memory forms of add write the sum back to memory.
// RL19: AND with memory or immediate, result to accumulator or memory, zero flag.
// RL20: Complement inverts the byte in place, zero flag only.
// RL21: Zero, carry from bit 7, aux carry from bit 3, signed overflow.
// RL22: No-operation takes one cycle and changes nothing.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module mec_core (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [15:0] prog_data_in,
   input wire logic wdt_timeout_in,
   input wire logic wake_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic [9:0] prog_addr_out,
   output logic wdt_clear_out,
   output logic halted_out,
   output logic master_irq_enable_out,
   output logic timeout_flag_out,
   output logic powerdown_flag_out
);
   mec_pkg::mec_state_t state;
   logic run;
   logic [9:0] pc;
   logic [9:0] stack_pc;
   logic [7:0] accumulator;
   logic [7:0] table_high_reg;
   logic [7:0] table_ptr;
   logic [7:0] tbl_dest;
   logic [3:0] flags;
   logic [1:0] pre_last;
   logic [7:0] ram [mec_pkg::RAM_DEPTH];
   logic exec;
   logic is_bit;
   logic is_br;
   logic gen;
   logic [7:0] opc;
   logic [7:0] opd;
   logic [2:0] bidx;
   logic [1:0] bkind;
   logic [7:0] mval;
   logic [7:0] addb;
   logic cin;
   logic [8:0] sum;
   logic [4:0] lsum;
   logic [3:0] arith_fl;
   logic [7:0] next_acc;
   logic [7:0] dm_wdata;
   logic [7:0] res;
   logic [3:0] next_fl;
   logic [9:0] next_pc;
   logic dm_we;
   logic fl_we;
   logic z_we;
   logic skip;
   logic extra;
   logic push;
   logic emi_set;
   logic wdt_plain;
   logic pre_a;
   logic pre_b;
   logic halt_go;
   logic tbl_go;
   logic tbl_last;
   logic pair_ok;
   logic clr_all;
   logic wen;
   logic [7:0] waddr;
   logic [7:0] wdata;
   logic bus_go;

   assign exec = run && (state == mec_pkg::ST_EXEC);
   assign opc = prog_data_in[15:8];
   assign opd = prog_data_in[7:0];
   assign bidx = prog_data_in[10:8];
   assign bkind = prog_data_in[13:12];
   assign is_bit = prog_data_in[15:14] == mec_pkg::CLS_BIT;
   assign is_br = prog_data_in[15:14] == mec_pkg::CLS_BR;
   assign gen = !is_bit && !is_br;

   // Operand read from the data space
   always_comb begin
      mval = 8'h00;
      if (opd[7:5] == mec_pkg::RAM_SEL) begin
         mval = ram[opd[4:0]];
      end else begin
         case (opd)
            mec_pkg::A_PCL: mval = pc[7:0];
            mec_pkg::A_TABLE_HIGH_REG: mval = table_high_reg;
            mec_pkg::A_TBLP: mval = table_ptr;
            mec_pkg::A_STATUS: mval = {2'h0, timeout_flag_out, powerdown_flag_out, flags};
            mec_pkg::A_INTC: mval = {7'h00, master_irq_enable_out};
            default: mval = 8'h00;
         endcase
      end
   end

   // Adder and its flags
   always_comb begin
      addb = (opc == mec_pkg::OP_ADD_AX || opc == mec_pkg::OP_AND_AX) ? opd : mval;
      cin = (opc == mec_pkg::OP_ADC_AM || opc == mec_pkg::OP_ADCM) && flags[mec_pkg::F_C];
      sum = {1'b0, accumulator} + {1'b0, addb} + {8'h00, cin};
      lsum = {1'b0, accumulator[3:0]} + {1'b0, addb[3:0]} + {4'h0, cin};
      arith_fl = flags;
      arith_fl[mec_pkg::F_C] = sum[8]; // see RL21
      arith_fl[mec_pkg::F_AC] = lsum[4];
      arith_fl[mec_pkg::F_Z] = sum[7:0] == 8'h00;
      arith_fl[mec_pkg::F_OV] = (accumulator[7] == addb[7]) && (sum[7] != accumulator[7]);
   end

   // Decode and execute
   always_comb begin
      next_acc = accumulator;
      dm_we = 1'b0;
      dm_wdata = mval;
      res = 8'h00;
      fl_we = 1'b0;
      z_we = 1'b0;
      skip = 1'b0;
      extra = 1'b0;
      next_pc = pc + 10'h001;
      push = 1'b0;
      emi_set = 1'b0;
      wdt_plain = 1'b0;
      pre_a = 1'b0;
      pre_b = 1'b0;
      halt_go = 1'b0;
      tbl_go = 1'b0;
      tbl_last = 1'b0;
      if (is_br) begin
         next_pc = prog_data_in[9:0]; // see RL3
         extra = 1'b1;
         push = prog_data_in[13];
      end else if (is_bit) begin
         case (bkind)
            mec_pkg::BK_CLR: begin
               dm_we = 1'b1;
               dm_wdata = mval & ~(8'h01 << bidx); // see RL2
            end
            mec_pkg::BK_SET: begin
               dm_we = 1'b1;
               dm_wdata = mval | (8'h01 << bidx); // see RL2
            end
            mec_pkg::BK_SZ: skip = !mval[bidx]; // see RL5
            default: skip = mval[bidx];
         endcase
      end else begin
         case (opc)
            mec_pkg::OP_MOV_AM: next_acc = mval; // see RL1
            mec_pkg::OP_MOV_MA: begin
               dm_we = 1'b1;
               dm_wdata = accumulator; // see RL1
            end
            mec_pkg::OP_MOV_AX: next_acc = opd;
            mec_pkg::OP_ADD_AM, mec_pkg::OP_ADD_AX, mec_pkg::OP_ADC_AM: begin
               next_acc = sum[7:0]; // see RL17
               fl_we = 1'b1;
            end
            mec_pkg::OP_ADDM, mec_pkg::OP_ADCM: begin
               dm_we = 1'b1;
               dm_wdata = sum[7:0]; // see RL18
               fl_we = 1'b1;
            end
            mec_pkg::OP_AND_AM, mec_pkg::OP_AND_AX: begin
               res = accumulator & addb; // see RL19
               next_acc = res;
               z_we = 1'b1;
            end
            mec_pkg::OP_ANDM: begin
               res = accumulator & mval;
               dm_we = 1'b1;
               dm_wdata = res;
               z_we = 1'b1;
            end
            mec_pkg::OP_CPL: begin
               res = ~mval; // see RL20
               dm_we = 1'b1;
               dm_wdata = res;
               z_we = 1'b1;
            end
            mec_pkg::OP_SZ: skip = mval == 8'h00; // see RL5
            mec_pkg::OP_SZA: begin
               next_acc = mval;
               skip = mval == 8'h00;
            end
            mec_pkg::OP_SIZ, mec_pkg::OP_SIZA: begin
               res = mval + 8'h01; // see RL6
               skip = res == 8'h00;
               dm_we = opc == mec_pkg::OP_SIZ;
               dm_wdata = res;
               if (opc == mec_pkg::OP_SIZA) next_acc = res;
            end
            mec_pkg::OP_SDZ, mec_pkg::OP_SDZA: begin
               res = mval - 8'h01; // see RL6
               skip = res == 8'h00;
               dm_we = opc == mec_pkg::OP_SDZ;
               dm_wdata = res;
               if (opc == mec_pkg::OP_SDZA) next_acc = res;
            end
            mec_pkg::OP_RET, mec_pkg::OP_RET_AX, mec_pkg::OP_RETURN_FROM_INTERRUPT: begin
               next_pc = stack_pc; // see RL7
               extra = 1'b1;
               if (opc == mec_pkg::OP_RET_AX) next_acc = opd;
               emi_set = opc == mec_pkg::OP_RETURN_FROM_INTERRUPT; // see RL8
            end
            mec_pkg::OP_TABLE_READ_CURRENT: tbl_go = 1'b1; // see RL9
            mec_pkg::OP_TABLE_READ_LAST_PAGE: begin
               tbl_go = 1'b1;
               tbl_last = 1'b1;
            end
            mec_pkg::OP_CLR_M: begin
               dm_we = 1'b1;
               dm_wdata = 8'h00; // see RL11
            end
            mec_pkg::OP_SET_M: begin
               dm_we = 1'b1;
               dm_wdata = 8'hff; // see RL11
            end
            mec_pkg::OP_SWAP: begin
               dm_we = 1'b1;
               dm_wdata = {mval[3:0], mval[7:4]}; // see RL14
            end
            mec_pkg::OP_SWAPA: next_acc = {mval[3:0], mval[7:4]};
            mec_pkg::OP_CLRWDT: wdt_plain = 1'b1;
            mec_pkg::OP_WDT_A: pre_a = 1'b1;
            mec_pkg::OP_WDT_B: pre_b = 1'b1;
            mec_pkg::OP_HALT: halt_go = 1'b1; // see RL15
            default: ; // see RL22
         endcase
      end
      next_fl = fl_we ? arith_fl : flags;
      if (z_we) next_fl[mec_pkg::F_Z] = res == 8'h00; // see RL21
      if (dm_we && opd == mec_pkg::A_PCL) begin
         next_pc = {pc[9:8], dm_wdata}; // see RL10
         extra = 1'b1;
      end
      if (skip) begin
         next_pc = pc + 10'h002; // see RL4
         extra = 1'b1;
      end
   end

   // Common data write port for execute and table cycles
   always_comb begin
      wen = exec && dm_we;
      waddr = opd;
      wdata = dm_wdata;
      if (run && state == mec_pkg::ST_TABLE) begin
         wen = 1'b1;
         waddr = tbl_dest;
         wdata = prog_data_in[7:0];
      end
   end

   always_ff @(posedge clk_in) begin
      if (wen && waddr[7:5] == mec_pkg::RAM_SEL) ram[waddr[4:0]] <= wdata;
   end

   // Sequencer
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= mec_pkg::ST_EXEC;
         pc <= mec_pkg::RESET_PC;
         prog_addr_out <= mec_pkg::RESET_PC;
         tbl_dest <= 8'h00;
      end else if (run) begin
         case (state)
            mec_pkg::ST_EXEC: begin
               pc <= next_pc;
               if (tbl_go) begin
                  prog_addr_out <= {tbl_last ? mec_pkg::LAST_PAGE : pc[9:8], table_ptr}; // see RL9
                  tbl_dest <= opd;
                  state <= mec_pkg::ST_TABLE;
               end else begin
                  prog_addr_out <= next_pc;
                  if (halt_go) state <= mec_pkg::ST_HALT; // see RL16
                  else if (extra) state <= mec_pkg::ST_BUBBLE; // see RL4
               end
            end
            mec_pkg::ST_BUBBLE: state <= mec_pkg::ST_EXEC;
            mec_pkg::ST_TABLE: begin
               prog_addr_out <= pc;
               state <= mec_pkg::ST_EXEC;
            end
            mec_pkg::ST_HALT: if (wake_in) state <= mec_pkg::ST_EXEC;
            default: state <= mec_pkg::ST_EXEC;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) halted_out <= 1'b0;
      else if (exec && halt_go) halted_out <= 1'b1;
      else if (run && state == mec_pkg::ST_HALT && wake_in) halted_out <= 1'b0;
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) accumulator <= 8'h00;
      else if (exec) accumulator <= next_acc;
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) flags <= 4'h0;
      else if (exec && (fl_we || z_we)) flags <= next_fl;
      else if (wen && waddr == mec_pkg::A_STATUS) flags <= wdata[3:0];
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) stack_pc <= mec_pkg::RESET_PC;
      else if (exec && push) stack_pc <= pc + 10'h001; // see RL3
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         table_high_reg <= 8'h00;
         table_ptr <= 8'h00;
      end else begin
         if (run && state == mec_pkg::ST_TABLE) table_high_reg <= prog_data_in[15:8]; // see RL9
         else if (wen && waddr == mec_pkg::A_TABLE_HIGH_REG) table_high_reg <= wdata;
         if (wen && waddr == mec_pkg::A_TBLP) table_ptr <= wdata;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) master_irq_enable_out <= 1'b0;
      else if (exec && emi_set) master_irq_enable_out <= 1'b1; // see RL8
      else if (wen && waddr == mec_pkg::A_INTC) master_irq_enable_out <= wdata[0];
   end

   // Watchdog clear and pairing of the pre-clears
   assign pair_ok = (pre_a && pre_last == mec_pkg::PRE_B) || (pre_b && pre_last == mec_pkg::PRE_A); // see RL13
   assign clr_all = exec && (wdt_plain || pair_ok); // see RL12

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) pre_last <= mec_pkg::PRE_NONE;
      else if (exec) begin
         if (pre_a && !pair_ok) pre_last <= mec_pkg::PRE_A;
         else if (pre_b && !pair_ok) pre_last <= mec_pkg::PRE_B;
         else pre_last <= mec_pkg::PRE_NONE; // see RL13
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         wdt_clear_out <= 1'b0;
         timeout_flag_out <= 1'b0;
         powerdown_flag_out <= 1'b0;
      end else begin
         wdt_clear_out <= clr_all || (exec && halt_go); // see RL16
         if (wdt_timeout_in) timeout_flag_out <= 1'b1;
         else if (clr_all || (exec && halt_go)) timeout_flag_out <= 1'b0; // see RL12
         if (exec && halt_go) powerdown_flag_out <= 1'b1; // see RL16
         else if (clr_all) powerdown_flag_out <= 1'b0;
      end
   end

   // Avalon-MM slave, one wait cycle per access
   assign bus_go = (avs_read_in || avs_write_in) && !avs_waitrequest_out;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h00000000;
      end else if (bus_go) begin
         avs_waitrequest_out <= 1'b1;
      end else if (avs_read_in || avs_write_in) begin
         avs_waitrequest_out <= 1'b0;
         case (avs_address_in)
            mec_pkg::R_CTRL: avs_readdata_out <= {31'h00000000, run};
            mec_pkg::R_STAT: avs_readdata_out <= {16'h0000, master_irq_enable_out, halted_out,
               timeout_flag_out, powerdown_flag_out, flags, accumulator};
            mec_pkg::R_PC: avs_readdata_out <= {22'h000000, pc};
            default: avs_readdata_out <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) run <= mec_pkg::CTRL_RUN_RST;
      else if (bus_go && avs_write_in && avs_address_in == mec_pkg::R_CTRL) run <= avs_writedata_in[0];
   end

   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);

   a_mov_imm: assert property (exec && gen && opc == mec_pkg::OP_MOV_AX |=> // see RL1
      accumulator == $past(opd) && flags == $past(flags)) else $error("immediate move wrong");
   a_bit_clear: assert property (exec && is_bit && bkind == mec_pkg::BK_CLR |-> // see RL2
      !dm_wdata[bidx] && ((dm_wdata ^ mval) & ~(8'h01 << bidx)) == 8'h00) else $error("bit clear wrong");
   a_call_push: assert property (exec && is_br && prog_data_in[13] |=> // see RL3
      stack_pc == $past(pc) + 10'h001 && state == mec_pkg::ST_BUBBLE) else $error("call push wrong");
   a_skip_two: assert property (exec && skip |=> // see RL4
      pc == $past(pc) + 10'h002 && state == mec_pkg::ST_BUBBLE) else $error("skip timing wrong");
   a_plain_one: assert property (exec && !extra && !tbl_go && !halt_go |=> // see RL22
      state == mec_pkg::ST_EXEC && pc == $past(pc) + 10'h001) else $error("one-cycle step wrong");
   a_return_from_interrupt_pc: assert property (exec && gen && opc == mec_pkg::OP_RETURN_FROM_INTERRUPT |=> // see RL8
      pc == $past(stack_pc) && master_irq_enable_out) else $error("interrupt return wrong");
   a_table_read: assert property (exec && tbl_go ##1 run |-> state == mec_pkg::ST_TABLE ##1 // see RL9
      table_high_reg == $past(prog_data_in[15:8]) && state == mec_pkg::ST_EXEC) else $error("table read wrong");
   a_pcl_write: assert property (exec && dm_we && opd == mec_pkg::A_PCL && !skip |=> // see RL10
      pc[7:0] == $past(dm_wdata) && state == mec_pkg::ST_BUBBLE) else $error("pc low write wrong");
   a_pre_alone: assert property (exec && pre_a && pre_last != mec_pkg::PRE_B |=> // see RL13
      !wdt_clear_out && $stable(powerdown_flag_out)) else $error("lone pre-clear acted");
   a_wdt_clear: assert property (exec && wdt_plain && !wdt_timeout_in |=> // see RL12
      wdt_clear_out && !timeout_flag_out && !powerdown_flag_out) else $error("watchdog clear wrong");
   a_halt_entry: assert property (exec && halt_go && !wdt_timeout_in |=> // see RL16
      halted_out && powerdown_flag_out && !timeout_flag_out && wdt_clear_out) else $error("halt entry wrong");
   a_add_flags: assert property (exec && gen && opc == mec_pkg::OP_ADD_AM |=> // see RL17
      flags[mec_pkg::F_C] == $past(sum[8]) && flags[mec_pkg::F_Z] == (accumulator == 8'h00))
      else $error("add flags wrong");

   c_skip: cover property (exec && skip ##2 exec);
   c_call: cover property (exec && is_br && prog_data_in[13]);
   c_table: cover property (exec && tbl_go ##2 state == mec_pkg::ST_EXEC);
   c_pair: cover property (exec && pair_ok);
   c_halt: cover property (halted_out ##1 !halted_out);
endmodule

// [core/mec_pkg.sv]
// Constants shared by the instruction execution core.
// Assumes a 16-bit program word and a byte-wide data space.
package mec_pkg;
   localparam int PC_W = 10;
   localparam logic [9:0] RESET_PC = 10'h000;
   // Word classes in bits 15:14
   localparam logic [1:0] CLS_BIT = 2'h2;
   localparam logic [1:0] CLS_BR = 2'h3;
   // Bit operation kinds in bits 13:12
   localparam logic [1:0] BK_CLR = 2'h0;
   localparam logic [1:0] BK_SET = 2'h1;
   localparam logic [1:0] BK_SZ = 2'h2;
   localparam logic [1:0] BK_SNZ = 2'h3;
   localparam logic [1:0] LAST_PAGE = 2'h3;
   // General opcodes in bits 15:8
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_MOV_AM = 8'h01;
   localparam logic [7:0] OP_MOV_MA = 8'h02;
   localparam logic [7:0] OP_MOV_AX = 8'h03;
   localparam logic [7:0] OP_ADD_AM = 8'h04;
   localparam logic [7:0] OP_ADDM = 8'h05;
   localparam logic [7:0] OP_ADD_AX = 8'h06;
   localparam logic [7:0] OP_ADC_AM = 8'h07;
   localparam logic [7:0] OP_ADCM = 8'h08;
   localparam logic [7:0] OP_AND_AM = 8'h09;
   localparam logic [7:0] OP_ANDM = 8'h0a;
   localparam logic [7:0] OP_AND_AX = 8'h0b;
   localparam logic [7:0] OP_CPL = 8'h0c;
   localparam logic [7:0] OP_SZ = 8'h0d;
   localparam logic [7:0] OP_SZA = 8'h0e;
   localparam logic [7:0] OP_SIZ = 8'h0f;
   localparam logic [7:0] OP_SDZ = 8'h10;
   localparam logic [7:0] OP_SIZA = 8'h11;
   localparam logic [7:0] OP_SDZA = 8'h12;
   localparam logic [7:0] OP_RET = 8'h13;
   localparam logic [7:0] OP_RET_AX = 8'h14;
   localparam logic [7:0] OP_RETURN_FROM_INTERRUPT = 8'h15;
   localparam logic [7:0] OP_TABLE_READ_CURRENT = 8'h16;
   localparam logic [7:0] OP_TABLE_READ_LAST_PAGE = 8'h17;
   localparam logic [7:0] OP_CLR_M = 8'h18;
   localparam logic [7:0] OP_SET_M = 8'h19;
   localparam logic [7:0] OP_SWAP = 8'h1a;
   localparam logic [7:0] OP_SWAPA = 8'h1b;
   localparam logic [7:0] OP_CLRWDT = 8'h1c;
   localparam logic [7:0] OP_WDT_A = 8'h1d;
   localparam logic [7:0] OP_WDT_B = 8'h1e;
   localparam logic [7:0] OP_HALT = 8'h1f;
   // Data space
   localparam logic [7:0] A_TBLP = 8'h05;
   localparam logic [7:0] A_PCL = 8'h06;
   localparam logic [7:0] A_TABLE_HIGH_REG = 8'h07;
   localparam logic [7:0] A_STATUS = 8'h0a;
   localparam logic [7:0] A_INTC = 8'h0b;
   localparam logic [2:0] RAM_SEL = 3'h1;
   localparam int RAM_DEPTH = 32;
   // Status bits
   localparam int F_C = 0;
   localparam int F_AC = 1;
   localparam int F_Z = 2;
   localparam int F_OV = 3;
   // Bus registers
   localparam logic [3:0] R_CTRL = 4'h0;
   localparam logic [3:0] R_STAT = 4'h4;
   localparam logic [3:0] R_PC = 4'h8;
   localparam logic CTRL_RUN_RST = 1'b1;
   localparam logic [1:0] PRE_NONE = 2'h0;
   localparam logic [1:0] PRE_A = 2'h1;
   localparam logic [1:0] PRE_B = 2'h2;
   typedef enum logic [1:0] {ST_EXEC, ST_BUBBLE, ST_TABLE, ST_HALT} mec_state_t;
endpackage

// [test/mec_prog_mem.sv]
// Program memory model: 1K words, read at the fetch address.
// Assumes the bench loads words by hierarchical writes, in reset or just before a scenario boots.
`timescale 1ns/10ps
module mec_prog_mem (
   input wire logic [9:0] addr_in,
   output logic [15:0] data_out
);
   logic [15:0] mem [0:1023];
   initial begin
      foreach (mem[i]) begin
         mem[i] = 16'h0000;
      end
   end
   // Same-cycle word, also the table word during table reads
   assign data_out = mem[addr_in];
endmodule

// [test/tb_mec_core.sv]
// Self-checking bench for the execution core, one task per scenario.
// Assumes the program memory model answers in the same cycle.
`timescale 1ns/10ps
module tb_mec_core;
   logic clk = 1'h0, rst = 1'h1, tmo = 1'h0, wake = 1'h0, rd = 1'h0, wr = 1'h0;
   logic wclr, hlt, irq, tof, powerdown_flag, wt;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, st;
   logic [15:0] pd;
   logic [9:0] pa;
   logic [15:0] prog[$];
   int err_count = 0, n_tests = 0, cycles = 0, cyc;
   mec_core u_mec_core (.clk_in(clk), .reset_in(rst), .prog_data_in(pd), .wdt_timeout_in(tmo), .wake_in(wake),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wt), .prog_addr_out(pa), .wdt_clear_out(wclr), .halted_out(hlt),
      .master_irq_enable_out(irq), .timeout_flag_out(tof), .powerdown_flag_out(powerdown_flag));
   mec_prog_mem u_mec_prog_mem (.addr_in(pa), .data_out(pd));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk); while (wt !== 1'b0);
      q = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   // Reset, load program, then a watchdog clear marker and a self loop
   task automatic boot();
      @(posedge clk);
      rst <= 1'h1;
      foreach (prog[i]) u_mec_prog_mem.mem[i] = prog[i];
      u_mec_prog_mem.mem[prog.size()] = 16'h1c00;
      u_mec_prog_mem.mem[prog.size() + 1] = 16'hc000 | 16'(prog.size() + 1);
      repeat (4) @(posedge clk);
      rst <= 1'h0;
   endtask
   // Cycles until the marker executes, then the status word
   task automatic run();
      boot();
      cyc = 0;
      while (wclr !== 1'b1 && cyc < 100) begin
         @(negedge clk);
         cyc++;
      end
      bus(1'h0, 4'h4, 32'h0, st);
   endtask
   task automatic s_bus();
      logic [31:0] q;
      logic [31:0] p;
      bus(1'h1, 4'hc, 32'hffff_ffff, q);
      bus(1'h0, 4'hc, 32'h0, q);
      check(q, 32'h0);
      bus(1'h0, 4'h0, 32'h0, q);
      check(q, 32'h1);
      // Pausing the core freezes the program counter
      bus(1'h1, 4'h0, 32'h0, q);
      bus(1'h0, 4'h0, 32'h0, q);
      check(q, 32'h0);
      bus(1'h0, 4'h8, 32'h0, p);
      repeat (3) @(posedge clk);
      bus(1'h0, 4'h8, 32'h0, q);
      check(q, p);
      bus(1'h1, 4'h0, 32'h1, q);
      bus(1'h0, 4'h8, 32'h0, q);
      check(q == p, 1'h0);
   endtask
   task automatic s_moves();
      prog = '{16'h035a, 16'h0220, 16'h9020, 16'h8620, 16'h1a20, 16'h1b20, 16'h0000, 16'h0420};
      run();
      check(cyc, 10);
      check(st, 32'h00cc);
   endtask
   task automatic s_arith();
      prog = '{16'h1921, 16'h0301, 16'h0821, 16'h0121, 16'h0680, 16'h0680, 16'h0b0f, 16'h0c21, 16'h0721};
      run();
      check(cyc, 11);
      check(st, 32'h0700);
   endtask
   task automatic s_skips();
      prog = '{16'h1922, 16'h0f22, 16'h03ee, 16'h0d22, 16'h03ee, 16'h1022, 16'ha022, 16'hb722, 16'h03ee,
         16'h0e22, 16'h1222, 16'h1122, 16'h03ee};
      run();
      check(cyc, 15);
      check(st, 32'h0000);
   endtask
   task automatic s_calls();
      u_mec_prog_mem.mem[10'h040] = 16'h1455;
      u_mec_prog_mem.mem[10'h041] = 16'h1500;
      u_mec_prog_mem.mem[10'h010] = 16'h1203;
      u_mec_prog_mem.mem[10'h310] = 16'h3021;
      prog = '{16'h0310, 16'h0205, 16'he040, 16'he041, 16'h1623, 16'h1724, 16'h0309, 16'h0206, 16'h03ee,
         16'h0123, 16'h0407, 16'h0424};
      run();
      check(cyc, 22);
      check(st, 32'h8054);
      check(irq, 1'h1);
   endtask
   task automatic s_wdt();
      logic [9:0] hold;
      prog = '{16'h1d00, 16'h1d00, 16'h1e00, 16'h1f00};
      boot();
      tmo <= 1'h1;
      @(posedge clk);
      tmo <= 1'h0;
      @(negedge clk);
      check({tof, wclr}, 2'h2);
      @(negedge clk);
      check({tof, wclr}, 2'h2);
      @(negedge clk);
      check({tof, wclr}, 2'h1);
      @(negedge clk);
      check({hlt, powerdown_flag, tof, wclr}, 4'hd);
      hold = pa;
      repeat (3) @(negedge clk);
      check({hlt, pa}, {1'h1, hold});
      @(posedge clk);
      tmo <= 1'h1;
      @(posedge clk);
      tmo <= 1'h0;
      wake <= 1'h1;
      @(posedge clk);
      wake <= 1'h0;
      for (int n = 0; n < 10 && wclr !== 1'b1; n++) @(negedge clk);
      check({wclr, powerdown_flag, tof}, 3'h4);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      s_bus();
      s_moves();
      s_arith();
      s_skips();
      s_calls();
      s_wdt();
      finish_test();
   end
endmodule
